// >>> hdl/mrc_defines.svh
// constants of the reset controller: timing counts and preset values
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH
`define MRC_CLK_PERIOD_PS 5000
`define MRC_LOW_SUPPLY_QUALIFY_TIME_US 1000
// qualify time rounds up to whole cycles (1 ms at 5 ns = 200000)
`define MRC_LOW_SUPPLY_QUALIFY_CYCLES \
  ((`MRC_LOW_SUPPLY_QUALIFY_TIME_US * 1000000 + `MRC_CLK_PERIOD_PS - 1) / `MRC_CLK_PERIOD_PS)
`define MRC_RESET_EXTENSION_CYCLES 1024
`define MRC_PORT_PRESET 8'hFF
`define MRC_PCL_PRESET 8'h00
`define MRC_WDT_SEL_PRESET 8'h07
`define MRC_WDT_SEL_LOW_MASK 8'h07
`define MRC_INT_HIGH_PRESET 8'h88
`define MRC_INT_LOW_PRESET 8'h00
`define MRC_STACK_TOP 4'h0
`define MRC_CNT_W 18
`endif

// >>> hdl/mrc_pkg.sv
// types shared by the reset controller
`default_nettype none
package mrc_pkg;
  typedef enum logic [2:0] {
    MRC_CAUSE_NONE,
    MRC_CAUSE_POWER_ON,
    MRC_CAUSE_PIN,
    MRC_CAUSE_LOW_SUPPLY,
    MRC_CAUSE_WDT_RUN,
    MRC_CAUSE_WDT_HALT,
    MRC_CAUSE_PIN_WAKE
  } mrc_cause_t;
  // one-cycle preset strobes and values sent to the core
  typedef struct packed {
    logic clearPc;
    logic clearStack;
    logic presetPorts;
    logic presetTimers;
    logic presetInterrupts;
    logic clearWatchdog;
    logic presetWdtSelFull;
    logic presetWdtSelLow;
    logic [7:0] portValue;
    logic [7:0] pclValue;
    logic [7:0] wdtSelValue;
    logic [7:0] intHighValue;
    logic [7:0] intLowValue;
    logic [3:0] stackValue;
  } mrc_preset_t;
endpackage
`default_nettype wire

// >>> hdl/mrc_reset_controller.sv
// reset controller: merges reset sources, extends release, keeps cause flags
`timescale 1ns/1ps
`include "mrc_defines.svh"
`default_nettype none
module mrc_reset_controller (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst,
  // reset sources
  input wire logic externalResetPinN,
  input wire logic lowSupplyDetect,
  input wire logic watchdogOverflow,
  input wire logic powerDownActive,
  // status flag writes from the core (e.g. halt entry, clear watchdog)
  input wire logic flagWrite,
  input wire logic flagWriteTimeout,
  input wire logic flagWritePowerDown,
  // outputs to the core
  output logic systemReset,
  output logic coreHold,
  output logic watchdogTimeoutFlag,
  output logic powerDownFlag,
  output mrc_pkg::mrc_cause_t lastCause,
  output mrc_pkg::mrc_preset_t preset
);
  import mrc_pkg::*;

  localparam logic [17:0] QualCycles = 18'(`MRC_LOW_SUPPLY_QUALIFY_CYCLES);
  localparam logic [17:0] ExtCycles = 18'(`MRC_RESET_EXTENSION_CYCLES);

  typedef enum logic [1:0] {MRC_RUN, MRC_HOLD, MRC_EXTEND} mrc_state_t;

  mrc_state_t state_q, state_d;
  logic [17:0] extCnt_q, extCnt_d;
  logic [17:0] lvCnt_q, lvCnt_d;
  logic lvFired_q, lvFired_d;
  logic pinPrev_q, pinPrev_d;
  logic to_q, to_d;
  logic pdf_q, pdf_d;
  mrc_cause_t cause_q, cause_d;
  mrc_preset_t preset_q, preset_d;
  logic por_q, por_d;
  logic lowSupplyEvent;
  logic pinFall;
  logic wdtRunEvent;
  logic wdtHaltEvent;

  // low-supply qualification: level must last past 1 ms, shorter glitches dropped
  always_comb
  begin
    lvCnt_d = lvCnt_q;
    lvFired_d = lvFired_q;
    lowSupplyEvent = 1'b0;
    if (!lowSupplyDetect)
    begin
      lvCnt_d = 18'h0;
      lvFired_d = 1'b0;
    end
    else if (lvCnt_q < QualCycles)
      lvCnt_d = lvCnt_q + 18'h1;
    else if (!lvFired_q)
    begin
      lowSupplyEvent = 1'b1;
      lvFired_d = 1'b1; // one reset per low-supply episode
    end
  end

  assign pinFall = pinPrev_q && !externalResetPinN;
  assign wdtRunEvent = watchdogOverflow && !powerDownActive && state_q == MRC_RUN;
  assign wdtHaltEvent = watchdogOverflow && powerDownActive && state_q == MRC_RUN;

  // sequencing, cause flags and presets
  always_comb
  begin
    state_d = state_q;
    extCnt_d = extCnt_q;
    pinPrev_d = externalResetPinN;
    to_d = to_q;
    pdf_d = pdf_q;
    cause_d = cause_q;
    por_d = 1'b0;
    preset_d = preset_q;
    preset_d.clearPc = 1'b0;
    preset_d.clearStack = 1'b0;
    preset_d.presetPorts = 1'b0;
    preset_d.presetTimers = 1'b0;
    preset_d.presetInterrupts = 1'b0;
    preset_d.clearWatchdog = 1'b0;
    preset_d.presetWdtSelFull = 1'b0;
    preset_d.presetWdtSelLow = 1'b0;
    // software flag writes; hardware sets below take priority
    if (flagWrite)
    begin
      to_d = flagWriteTimeout;
      pdf_d = flagWritePowerDown;
    end
    case (state_q)
      MRC_RUN:
      begin
        if (pinFall || !externalResetPinN || lowSupplyEvent || wdtRunEvent)
        begin
          state_d = MRC_HOLD;
          if (wdtRunEvent)
          begin
            to_d = 1'b1;
            cause_d = MRC_CAUSE_WDT_RUN;
          end
          else if (lowSupplyEvent)
            cause_d = MRC_CAUSE_LOW_SUPPLY;
          else if (powerDownActive)
          begin
            to_d = 1'b0;
            pdf_d = 1'b1;
            cause_d = MRC_CAUSE_PIN_WAKE;
          end
          else
            cause_d = MRC_CAUSE_PIN;
          // full preset set, general registers untouched
          preset_d.clearPc = 1'b1;
          preset_d.clearStack = 1'b1;
          preset_d.presetPorts = 1'b1;
          preset_d.presetTimers = 1'b1;
          preset_d.presetInterrupts = 1'b1;
          preset_d.clearWatchdog = 1'b1;
          preset_d.presetWdtSelFull = 1'b1;
        end
        else if (wdtHaltEvent)
        begin
          // halt time-out: only PC, stack, watchdog clear and low select bits, flags 1,1
          to_d = 1'b1;
          pdf_d = 1'b1;
          cause_d = MRC_CAUSE_WDT_HALT;
          preset_d.clearPc = 1'b1;
          preset_d.clearStack = 1'b1;
          preset_d.presetWdtSelLow = 1'b1;
          preset_d.clearWatchdog = 1'b1;
        end
      end
      MRC_HOLD:
      begin
        // stay while pin or supply still low
        extCnt_d = 18'h0;
        if (externalResetPinN && !lowSupplyDetect)
          state_d = MRC_EXTEND;
      end
      MRC_EXTEND:
      begin
        if (!externalResetPinN || lowSupplyEvent)
        begin
          state_d = MRC_HOLD;
          extCnt_d = 18'h0;
        end
        else if (extCnt_q >= ExtCycles - 18'h1)
        begin
          state_d = MRC_RUN;
          preset_d.clearPc = 1'b1;
          preset_d.clearWatchdog = 1'b1;
        end
        else
          extCnt_d = extCnt_q + 18'h1;
      end
      default:
        state_d = MRC_HOLD;
    endcase
    if (por_q)
    begin
      // first cycle after power-on: full preset set (all strobes but presetWdtSelLow), flags cleared
      to_d = 1'b0;
      pdf_d = 1'b0;
      cause_d = MRC_CAUSE_POWER_ON;
      preset_d.clearPc = 1'b1;
      preset_d.clearStack = 1'b1;
      preset_d.presetPorts = 1'b1;
      preset_d.presetTimers = 1'b1;
      preset_d.presetInterrupts = 1'b1;
      preset_d.clearWatchdog = 1'b1;
      preset_d.presetWdtSelFull = 1'b1;
    end
  end

  // registers; power-on leaves the block holding the core through the extension
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= MRC_HOLD;
      extCnt_q <= 18'h0;
      lvCnt_q <= 18'h0;
      lvFired_q <= 1'b0;
      pinPrev_q <= 1'b1;
      to_q <= 1'b0;
      pdf_q <= 1'b0;
      cause_q <= MRC_CAUSE_POWER_ON;
      por_q <= 1'b1;
      preset_q <= '{clearPc: 1'b0, clearStack: 1'b0, presetPorts: 1'b0,
                    presetTimers: 1'b0, presetInterrupts: 1'b0, clearWatchdog: 1'b0,
                    presetWdtSelFull: 1'b0, presetWdtSelLow: 1'b0,
                    portValue: `MRC_PORT_PRESET, pclValue: `MRC_PCL_PRESET,
                    wdtSelValue: `MRC_WDT_SEL_PRESET, intHighValue: `MRC_INT_HIGH_PRESET,
                    intLowValue: `MRC_INT_LOW_PRESET, stackValue: `MRC_STACK_TOP};
    end
    else
    begin
      state_q <= state_d;
      extCnt_q <= extCnt_d;
      lvCnt_q <= lvCnt_d;
      lvFired_q <= lvFired_d;
      pinPrev_q <= pinPrev_d;
      to_q <= to_d;
      pdf_q <= pdf_d;
      cause_q <= cause_d;
      por_q <= por_d;
      preset_q <= preset_d;
    end
  end

  // the core runs only in RUN; reset and hold are decoded from state_q, the rest leave flip-flops
  assign systemReset = state_q != MRC_RUN;
  assign coreHold = state_q != MRC_RUN;
  assign watchdogTimeoutFlag = to_q;
  assign powerDownFlag = pdf_q;
  assign lastCause = cause_q;
  assign preset = preset_q;
endmodule // mrc_reset_controller
`default_nettype wire

// >>> verif/mrc_reset_controller_chk.sv
// port assertions for the reset controller
`timescale 1ns/1ps
`default_nettype none
module mrc_reset_controller_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // sources
  input wire logic externalResetPinN,
  input wire logic lowSupplyDetect,
  input wire logic watchdogOverflow,
  input wire logic powerDownActive,
  // outputs
  input wire logic systemReset,
  input wire logic coreHold,
  input wire logic watchdogTimeoutFlag,
  input wire logic powerDownFlag,
  input wire mrc_pkg::mrc_preset_t preset
);
  import mrc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // answers may land one or two edges after the cause, hence 1:2
  a_pin_rise: assert property (!systemReset && !powerDownActive && !externalResetPinN
    |-> ##[1:2] (systemReset && coreHold)) else $error("pin reset missing");
  a_pin_hold: assert property (systemReset && !externalResetPinN |=> systemReset)
    else $error("left reset with pin low");
  a_wdt_run: assert property (watchdogOverflow && !powerDownActive && !systemReset
    |-> ##[1:2] (systemReset && watchdogTimeoutFlag)) else $error("wdt run reset");
  a_wdt_halt: assert property (watchdogOverflow && powerDownActive && !systemReset
    && externalResetPinN && !lowSupplyDetect
    |-> ##[1:2] (watchdogTimeoutFlag && powerDownFlag && preset.clearStack))
    else $error("wdt halt reset");
  a_preset_vals: assert property (preset.presetPorts |-> preset.portValue == 8'hFF
    && preset.intHighValue == 8'h88 && preset.wdtSelValue == 8'h07 && preset.pclValue == 8'h00)
    else $error("preset values");
  a_sel_low: assert property (preset.presetWdtSelLow |-> !preset.presetWdtSelFull
    && !preset.presetPorts && !preset.presetTimers) else $error("halt preset too wide");
  a_sync_release: assert property ($fell(systemReset) |-> externalResetPinN
    && $past(externalResetPinN, 8)) else $error("release with pin low");
  a_irq_off: assert property ($rose(systemReset) |-> ##[0:1] preset.presetInterrupts)
    else $error("interrupts not preset");
  // main scenarios
  c_pin: cover property (!externalResetPinN && !systemReset);
  c_halt: cover property (watchdogOverflow && powerDownActive);
  c_rel: cover property ($fell(systemReset));
endmodule // mrc_reset_controller_chk
`default_nettype wire

// >>> verif/mrc_reset_switch.sv
// reset switch model on the active-low reset pin
`timescale 1ns/1ps
`default_nettype none
module mrc_reset_switch (
  // clock and pin
  input wire logic ref_clk,
  output logic pinN
);
  // pulled up while the switch is open
  initial pinN = 1'b1;
  // press for n cycles; the pin moves just after an edge only
  task automatic press(input int n);
    @(posedge ref_clk);
    #1 pinN = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1 pinN = 1'b1;
  endtask
endmodule // mrc_reset_switch
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the reset controller
`timescale 1ns/1ps
`include "mrc_defines.svh"
`default_nettype none
module tb_top;
  import mrc_pkg::*;
  logic ref_clk, rst, pinN, lowSup, wdo, pdn, fw, fwTo, fwPd, sysRst, hold, toF, power_down_flag;
  mrc_cause_t cause;
  mrc_preset_t pre, seen;
  int miscompares, samples_checked;
  mrc_reset_switch sw (.ref_clk(ref_clk), .pinN(pinN));
  mrc_reset_controller dut (.ref_clk(ref_clk), .rst(rst), .externalResetPinN(pinN),
    .lowSupplyDetect(lowSup), .watchdogOverflow(wdo), .powerDownActive(pdn), .flagWrite(fw),
    .flagWriteTimeout(fwTo), .flagWritePowerDown(fwPd), .systemReset(sysRst), .coreHold(hold),
    .watchdogTimeoutFlag(toF), .powerDownFlag(power_down_flag), .lastCause(cause), .preset(pre));
  // 200 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // sticky strobe record, since one-cycle pulses are easy to miss
  always @(posedge ref_clk) seen <= seen | pre;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait for release, n counts the cycles
  task automatic waitRel(output int n);
    n = 0;
    while (sysRst !== 1'b0 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    if (n == 2000)
    begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic tPowerOn();
    int n;
    chk("flags", {6'h0, toF, power_down_flag}, 8'h00);
    chk("cause", 8'(cause), 8'(MRC_CAUSE_POWER_ON));
    waitRel(n);
    chk("strobes", 8'(seen[51:45]), 8'h7F);
    $display("power-on done");
  endtask
  task automatic tWdtRun();
    int n;
    seen = '0;
    wdo = 1'b1;
    cyc(1);
    wdo = 1'b0;
    cyc(3);
    chk("flags", {6'h0, toF, power_down_flag}, 8'h02);
    chk("cause", 8'(cause), 8'(MRC_CAUSE_WDT_RUN));
    waitRel(n);
    chk("strobes", 8'(seen[51:45]), 8'h7F);
    $display("wdt run done");
  endtask
  task automatic tPin();
    int n;
    seen = '0;
    sw.press(4);
    chk("sysRst", 8'(sysRst), 8'h01);
    chk("cause", 8'(cause), 8'(MRC_CAUSE_PIN));
    chk("flags", {6'h0, toF, power_down_flag}, 8'h02);
    waitRel(n);
    chk("extend", 8'(n >= `MRC_RESET_EXTENSION_CYCLES && n <= `MRC_RESET_EXTENSION_CYCLES + 6), 8'h01);
    chk("strobes", 8'(seen[51:45]), 8'h7F);
    $display("pin done");
  endtask
  task automatic tHalt();
    // software load of the flags, then a clearing write in the same cycle as the halt time-out
    fw = 1'b1;
    fwPd = 1'b1;
    cyc(1);
    chk("flag write", {6'h0, toF, power_down_flag}, 8'h01);
    fwPd = 1'b0;
    pdn = 1'b1;
    seen = '0;
    wdo = 1'b1;
    cyc(1);
    fw = 1'b0;
    wdo = 1'b0;
    cyc(3);
    chk("sysRst", 8'(sysRst), 8'h00);
    chk("flags", {6'h0, toF, power_down_flag}, 8'h03);
    chk("cause", 8'(cause), 8'(MRC_CAUSE_WDT_HALT));
    chk("strobes", seen[51:44], 8'hC5);
    $display("halt done");
  endtask
  task automatic tWake();
    int n;
    sw.press(3);
    pdn = 1'b0;
    chk("flags", {6'h0, toF, power_down_flag}, 8'h01);
    chk("cause", 8'(cause), 8'(MRC_CAUSE_PIN_WAKE));
    waitRel(n);
    lowSup = 1'b1;
    cyc(100);
    chk("glitch", 8'(sysRst), 8'h00);
    lowSup = 1'b0;
    $display("wake and glitch done");
  endtask
  initial
  begin
    rst = 1'b1;
    {lowSup, wdo, pdn, fw, fwTo, fwPd} = '0;
    seen = '0;
    miscompares = 0;
    samples_checked = 0;
    cyc(16);
    rst = 1'b0;
    cyc(2);
    tPowerOn();
    tWdtRun();
    tPin();
    tHalt();
    tWake();
    summarize();
  end
endmodule // tb_top
bind mrc_reset_controller mrc_reset_controller_chk chk_i (.ref_clk(ref_clk), .rst(rst),
  .externalResetPinN(externalResetPinN), .lowSupplyDetect(lowSupplyDetect),
  .watchdogOverflow(watchdogOverflow), .powerDownActive(powerDownActive),
  .systemReset(systemReset), .coreHold(coreHold), .watchdogTimeoutFlag(watchdogTimeoutFlag),
  .powerDownFlag(powerDownFlag), .preset(preset));
`default_nettype wire
